// ---- pcsp_pkg.sv ----
// package for the program counter and stack pointer block
//
// Overview of operation
// - 14-bit program counter, reset to zero
// - normal advance touches only low 8 bits
// - page-advance increments upper 6 bits and clears low 8 bits
// - interrupt or call saves counter and flags
// - only interrupt-exit restores counter and flags
// - no firmware counter access; stack in SRAM
// - program stack pointer resets to zero, grows up
// - load program stack pointer from accumulator
// - acknowledge: disable, write byte, increment, twice
// - interrupt-exit: decrement, restore twice, then enable
// - call pushes, pointer increased by two
// - subroutine-exit restores counter only, pointer minus two
// - stack-store pre-decrements then writes
// - stack-load reads then post-increments
// - reset clears data stack pointer
// - store at zero pointer wraps to 0xFF
// - exchange accumulator with data stack pointer
// - direct operand uses one-byte SRAM address
// - indexed address is constant plus index register
package pcsp_pkg;

    localparam int PC_W = 14;
    localparam int PC_LO_W = 8;
    localparam int PC_HI_W = 6;
    localparam int DATA_W = 8;
    localparam logic [13:0] PC_RESET = 14'h0000;
    localparam logic [7:0] PSP_RESET = 8'h00;
    localparam logic [7:0] DSP_RESET = 8'h00;
    localparam logic [7:0] PTR_ONE = 8'h01;
    // saved byte layout: first byte holds flags and upper counter bits
    localparam int SAV_CARRY_BIT = 7;
    localparam int SAV_ZERO_BIT = 6;

    // operation requested by the instruction decoder
    typedef enum logic [3:0] {
        PCSP_OP_NONE,
        PCSP_OP_STEP,
        PCSP_OP_PAGE,
        PCSP_OP_JUMP,
        PCSP_OP_CALL,
        PCSP_OP_INTACK,
        PCSP_OP_RET,
        PCSP_OP_INTERRUPT_EXIT_INSTR,
        PCSP_OP_LDPSP,
        PCSP_OP_PUSH,
        PCSP_OP_POP,
        PCSP_OP_SWAPDSP,
        PCSP_OP_OPADDR
    } pcsp_op_t;

    typedef enum logic [1:0] {
        PCSP_AM_IMM,
        PCSP_AM_DIRECT,
        PCSP_AM_INDEX
    } pcsp_amode_t;

    typedef struct packed {
        pcsp_op_t op;
        pcsp_amode_t amode;
        logic [7:0] operand;
        logic [13:0] target;
        logic [7:0] acc;
        logic [7:0] idx;
        logic carry;
        logic zero;
    } pcsp_req_t;

    typedef struct packed {
        logic we;
        logic re;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pcsp_mem_t;

endpackage : pcsp_pkg

// ---- pcsp_core.sv ----
// program counter, program stack and data stack pointer logic
module pcsp_core
    import pcsp_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire pcsp_req_t req_i,
    input wire logic req_valid_i,
    input wire logic [7:0] mem_rdata_i,
    output logic req_ready_o,
    output pcsp_mem_t mem_o,
    output logic [13:0] program_counter_o,
    output logic [7:0] program_stack_pointer_o,
    output logic [7:0] data_stack_pointer_o,
    output logic [7:0] acc_o,
    output logic acc_valid_o,
    output logic [7:0] operand_o,
    output logic operand_valid_o,
    output logic carry_o,
    output logic zero_o,
    output logic flags_valid_o,
    output logic int_enable_o
);

    // -------------------------------------------------------------
    // sequencer states
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        PCSP_IDLE,
        PCSP_PUSH2,
        PCSP_POP1,
        PCSP_POP2,
        PCSP_POPW,
        PCSP_DWAIT,
        PCSP_DPOP
    } pcsp_state_t;

    pcsp_state_t state_r, state_nxt;
    logic [13:0] pc_r;
    logic [7:0] psp_r;
    logic [7:0] dsp_r;
    logic [7:0] sav_lo_r;
    logic [7:0] pop_lo_r;
    logic interrupt_exit_instr_r;
    logic ie_r;
    pcsp_mem_t mem_r, mem_nxt;
    logic [7:0] acc_r;
    logic acc_v_r;
    logic [7:0] opnd_r;
    logic opnd_v_r;
    logic cy_r, z_r, fl_v_r;

    // -------------------------------------------------------------
    // decoding
    // -------------------------------------------------------------
    wire logic take = req_valid_i && (state_r == PCSP_IDLE);
    wire logic [7:0] pc_lo_inc = pc_r[7:0] + PTR_ONE;
    wire logic [13:0] pc_step = {pc_r[13:8], pc_lo_inc};
    wire logic [5:0] pc_hi_inc = pc_r[13:8] + 6'h01;
    wire logic [13:0] pc_page = {pc_hi_inc, 8'h00};
    wire logic [7:0] psp_inc = psp_r + PTR_ONE;
    wire logic [7:0] psp_dec = psp_r - PTR_ONE;
    wire logic [7:0] dsp_dec = dsp_r - PTR_ONE;
    wire logic [7:0] dsp_inc = dsp_r + PTR_ONE;
    // first saved byte: carry, zero, upper counter bits of the return point
    wire logic [7:0] sav_hi = {req_i.carry, req_i.zero, pc_r[13:8]};
    wire logic [7:0] idx_addr = req_i.operand + req_i.idx;

    function automatic logic [7:0] op_addr(input pcsp_amode_t am, input logic [7:0] k,
                                           input logic [7:0] ia);
        case (am)
            PCSP_AM_DIRECT: op_addr = k;
            PCSP_AM_INDEX: op_addr = ia;
            default: op_addr = 8'h00;
        endcase
    endfunction : op_addr

    assign req_ready_o = (state_r == PCSP_IDLE);

    // -------------------------------------------------------------
    // memory command and next state
    // -------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        mem_nxt = '0;
        case (state_r)
            PCSP_IDLE: begin
                if (take) begin
                    case (req_i.op)
                        PCSP_OP_CALL, PCSP_OP_INTACK: begin
                            mem_nxt = '{we: 1'b1, re: 1'b0, addr: psp_r, wdata: sav_hi};
                            state_nxt = PCSP_PUSH2;
                        end
                        PCSP_OP_RET, PCSP_OP_INTERRUPT_EXIT_INSTR: begin
                            mem_nxt = '{we: 1'b0, re: 1'b1, addr: psp_dec, wdata: 8'h00};
                            state_nxt = PCSP_POP1;
                        end
                        PCSP_OP_PUSH: begin
                            mem_nxt = '{we: 1'b1, re: 1'b0, addr: dsp_dec, wdata: req_i.acc};
                        end
                        PCSP_OP_POP: begin
                            mem_nxt = '{we: 1'b0, re: 1'b1, addr: dsp_r, wdata: 8'h00};
                            state_nxt = PCSP_DWAIT;
                        end
                        PCSP_OP_OPADDR: begin
                            if (req_i.amode != PCSP_AM_IMM) begin
                                mem_nxt.re = 1'b1;
                                mem_nxt.addr = op_addr(req_i.amode, req_i.operand, idx_addr);
                                state_nxt = PCSP_DWAIT;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            PCSP_PUSH2: begin
                mem_nxt = '{we: 1'b1, re: 1'b0, addr: psp_r, wdata: sav_lo_r};
                state_nxt = PCSP_IDLE;
            end
            PCSP_POP1: begin
                mem_nxt = '{we: 1'b0, re: 1'b1, addr: psp_dec, wdata: 8'h00};
                state_nxt = PCSP_POP2;
            end
            PCSP_POP2: state_nxt = PCSP_POPW;
            PCSP_POPW: state_nxt = PCSP_IDLE;
            // sram answers one cycle after the command, as on the program stack pops
            PCSP_DWAIT: state_nxt = PCSP_DPOP;
            PCSP_DPOP: state_nxt = PCSP_IDLE;
            default: state_nxt = PCSP_IDLE;
        endcase
    end

    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= PCSP_IDLE;
            pc_r <= PC_RESET;
            psp_r <= PSP_RESET;
            dsp_r <= DSP_RESET;
            sav_lo_r <= 8'h00;
            pop_lo_r <= 8'h00;
            interrupt_exit_instr_r <= 1'b0;
            ie_r <= 1'b0;
            mem_r <= '0;
            acc_r <= 8'h00;
            acc_v_r <= 1'b0;
            opnd_r <= 8'h00;
            opnd_v_r <= 1'b0;
            cy_r <= 1'b0;
            z_r <= 1'b0;
            fl_v_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            mem_r <= mem_nxt;
            acc_v_r <= 1'b0;
            opnd_v_r <= 1'b0;
            fl_v_r <= 1'b0;
            case (state_r)
                PCSP_IDLE: begin
                    if (take) begin
                        case (req_i.op)
                            PCSP_OP_STEP: pc_r <= pc_step;
                            PCSP_OP_PAGE: pc_r <= pc_page;
                            PCSP_OP_JUMP: pc_r <= req_i.target;
                            PCSP_OP_CALL, PCSP_OP_INTACK: begin
                                sav_lo_r <= pc_r[7:0];
                                psp_r <= psp_inc;
                                if (req_i.op == PCSP_OP_INTACK) begin
                                    ie_r <= 1'b0;
                                end
                                pc_r <= req_i.target;
                            end
                            PCSP_OP_RET, PCSP_OP_INTERRUPT_EXIT_INSTR: begin
                                psp_r <= psp_dec;
                                interrupt_exit_instr_r <= (req_i.op == PCSP_OP_INTERRUPT_EXIT_INSTR);
                            end
                            PCSP_OP_LDPSP: psp_r <= req_i.acc;
                            PCSP_OP_PUSH: dsp_r <= dsp_dec;
                            PCSP_OP_POP: dsp_r <= dsp_inc;
                            PCSP_OP_SWAPDSP: begin
                                dsp_r <= req_i.acc;
                                acc_r <= dsp_r;
                                acc_v_r <= 1'b1;
                            end
                            PCSP_OP_OPADDR: begin
                                if (req_i.amode == PCSP_AM_IMM) begin
                                    opnd_r <= req_i.operand;
                                    opnd_v_r <= 1'b1;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                PCSP_PUSH2: psp_r <= psp_inc;
                PCSP_POP1: psp_r <= psp_dec;
                PCSP_POP2: pop_lo_r <= mem_rdata_i;
                PCSP_POPW: begin
                    pc_r <= {mem_rdata_i[5:0], pop_lo_r};
                    if (interrupt_exit_instr_r) begin
                        cy_r <= mem_rdata_i[SAV_CARRY_BIT];
                        z_r <= mem_rdata_i[SAV_ZERO_BIT];
                        fl_v_r <= 1'b1;
                        ie_r <= 1'b1;
                    end
                end
                PCSP_DPOP: begin
                    opnd_r <= mem_rdata_i;
                    opnd_v_r <= 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // counter only leaves the block as an output; nothing writes it but the sequencer
    assign program_counter_o = pc_r;
    assign program_stack_pointer_o = psp_r;
    assign data_stack_pointer_o = dsp_r;
    assign mem_o = mem_r;
    assign acc_o = acc_r;
    assign acc_valid_o = acc_v_r;
    assign operand_o = opnd_r;
    assign operand_valid_o = opnd_v_r;
    assign carry_o = cy_r;
    assign zero_o = z_r;
    assign flags_valid_o = fl_v_r;
    assign int_enable_o = ie_r;

endmodule : pcsp_core

// ---- pcsp_core_props.sv ----
// concurrent checks on the ports of the counter and stack pointer block
module pcsp_core_props
    import pcsp_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire pcsp_req_t req_i,
    input wire logic req_valid_i,
    input wire logic req_ready_o,
    input wire pcsp_mem_t mem_o,
    input wire logic [13:0] program_counter_o,
    input wire logic [7:0] program_stack_pointer_o,
    input wire logic [7:0] data_stack_pointer_o,
    input wire logic flags_valid_o,
    input wire logic int_enable_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tk;
    pcsp_op_t op;
    logic [13:0] pcnt;
    logic [7:0] pstk;
    logic [7:0] dstk;
    logic [7:0] ea;
    assign tk = req_valid_i && req_ready_o;
    assign op = req_i.op;
    assign pcnt = program_counter_o;
    assign pstk = program_stack_pointer_o;
    assign dstk = data_stack_pointer_o;
    // a refused request must not count, so every antecedent needs ready too
    assign ea = req_i.operand + (req_i.amode == PCSP_AM_INDEX ? req_i.idx : 8'h00);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    step_low_a: assert property (
        tk && op == PCSP_OP_STEP |=> pcnt == {$past(pcnt[13:8]), $past(pcnt[7:0]) + 8'h01})
        else $error("step moved the counter wrongly");
    page_step_a: assert property (
        tk && op == PCSP_OP_PAGE |=> pcnt == {$past(pcnt[13:8]) + 6'h01, 8'h00})
        else $error("page advance moved the counter wrongly");
    call_save_a: assert property (
        tk && op == PCSP_OP_CALL |=> mem_o.we && mem_o.addr == $past(pstk)
        && mem_o.wdata == {$past(req_i.carry), $past(req_i.zero), $past(pcnt[13:8])}
        ##1 mem_o.we && mem_o.addr == $past(pstk, 2) + 8'h01 && pstk == $past(pstk, 2) + 8'h02)
        else $error("call save sequence wrong");
    ack_disable_a: assert property (
        tk && op == PCSP_OP_INTACK |=> !int_enable_o && mem_o.we && mem_o.addr == $past(pstk)
        ##1 mem_o.we && pstk == $past(pstk, 2) + 8'h02)
        else $error("acknowledge save sequence wrong");
    sub_exit_a: assert property (
        tk && op == PCSP_OP_RET |=> !flags_valid_o [*4] ##0 pstk == $past(pstk, 4) - 8'h02)
        else $error("subroutine exit touched flags or pointer");
    int_exit_a: assert property (
        tk && op == PCSP_OP_INTERRUPT_EXIT_INSTR |-> ##4 int_enable_o && flags_valid_o
        && pstk == $past(pstk, 4) - 8'h02)
        else $error("interrupt exit restore wrong");
    push_pre_a: assert property (
        tk && op == PCSP_OP_PUSH |=> mem_o.we && dstk == $past(dstk) - 8'h01 && mem_o.addr == dstk)
        else $error("store did not pre-decrement");
    pop_post_a: assert property (
        tk && op == PCSP_OP_POP |=> mem_o.re && mem_o.addr == $past(dstk)
        && dstk == $past(dstk) + 8'h01)
        else $error("load did not post-increment");
    operand_addr_a: assert property (
        tk && op == PCSP_OP_OPADDR && req_i.amode != PCSP_AM_IMM |=> mem_o.re
        && mem_o.addr == $past(ea))
        else $error("operand address wrong");
    cover property (tk && op == PCSP_OP_INTERRUPT_EXIT_INSTR);
    cover property (tk && op == PCSP_OP_PUSH && dstk == 8'h00);
    cover property (tk && op == PCSP_OP_OPADDR && req_i.amode == PCSP_AM_INDEX);
endmodule : pcsp_core_props

// ---- testbench.sv ----
// self-checking bench for the counter and stack pointer block
module testbench
    import pcsp_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    pcsp_req_t req_i = '0;
    logic req_valid_i = 1'b0;
    logic [7:0] mem_rdata_i = 8'h00;
    logic req_ready_o;
    pcsp_mem_t mem_o;
    logic [13:0] program_counter_o;
    logic [7:0] program_stack_pointer_o;
    logic [7:0] data_stack_pointer_o;
    logic [7:0] acc_o;
    logic acc_valid_o;
    logic [7:0] operand_o;
    logic operand_valid_o;
    logic carry_o;
    logic zero_o;
    logic flags_valid_o;
    logic int_enable_o;
    logic [7:0] mem [256];
    logic [17:0] q [$];
    logic rd_pend = 1'b0;
    logic [7:0] rd_addr = 8'h00;
    logic [15:0] rng = 16'hc55c;
    logic [7:0] v1;
    logic [7:0] v2;
    pcsp_req_t r = '0;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;

    pcsp_core DUT (.*);
    always #10 clk_i = ~clk_i;

    function automatic logic [7:0] rnd();
        rng ^= rng << 7;
        rng ^= rng >> 9;
        rng ^= rng << 8;
        return rng[7:0];
    endfunction : rnd
    function automatic logic [17:0] nxt();
        return q.size() > 0 ? q.pop_front() : 18'h3_ffff;
    endfunction : nxt
    function automatic void ex(logic [1:0] k, logic [7:0] a, logic [7:0] d);
        q.push_back({k, a, d});
    endfunction : ex
    task automatic check(string name, logic [17:0] got, logic [17:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic give_verdict();
        if (n_mismatch == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict
    // valid stays up while busy, so a refused copy of the last request is offered
    task automatic issue(pcsp_op_t op);
        @(negedge clk_i);
        while (!req_ready_o) @(negedge clk_i);
        r.op = op;
        req_i <= r;
        req_valid_i <= 1'b1;
    endtask : issue
    task automatic idle();
        @(negedge clk_i);
        req_valid_i <= 1'b0;
        repeat (5) @(negedge clk_i);
    endtask : idle
    task automatic reset();
        reset_n_i <= 1'b0;
        repeat (6) @(negedge clk_i);
        reset_n_i <= 1'b1;
        @(negedge clk_i);
        check("state", {program_counter_o, req_ready_o, int_enable_o, carry_o, zero_o}, 18'h0_0008);
        check("pointers", {2'h0, program_stack_pointer_o, data_stack_pointer_o}, 18'h0_0000);
    endtask : reset

    // ----------------------------------------------------------------
    // sram model and result monitor
    // ----------------------------------------------------------------
    // read data is shown one cycle late and scrambled when no read is pending
    always @(negedge clk_i) begin
        rd_pend <= mem_o.re;
        rd_addr <= mem_o.addr;
        mem_rdata_i <= rd_pend ? mem[rd_addr] : ~mem_rdata_i;
        if (mem_o.we) mem[mem_o.addr] = mem_o.wdata;
        if (reset_n_i && mem_o.we) check("write", {2'h0, mem_o.addr, mem_o.wdata}, nxt());
        if (reset_n_i && operand_valid_o) check("operand", {10'h100, operand_o}, nxt());
        if (reset_n_i && acc_valid_o) check("swap", {10'h200, acc_o}, nxt());
        if (reset_n_i && flags_valid_o) check("flags", {16'hc000, carry_o, zero_o}, nxt());
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    initial begin
        reset();
        r.target = 14'h01fe;
        issue(PCSP_OP_JUMP);
        issue(PCSP_OP_STEP);
        issue(PCSP_OP_STEP);
        idle();
        check("wrap", {4'h0, program_counter_o}, 18'h0_0100);
        issue(PCSP_OP_PAGE);
        idle();
        check("page", {4'h0, program_counter_o}, 18'h0_0200);
        r.carry = 1'b1;
        r.target = 14'h0345;
        ex(2'h0, 8'h00, 8'h82);
        ex(2'h0, 8'h01, 8'h00);
        issue(PCSP_OP_CALL);
        r.carry = 1'b0;
        r.zero = 1'b1;
        r.target = 14'h0004;
        ex(2'h0, 8'h02, 8'h43);
        ex(2'h0, 8'h03, 8'h45);
        issue(PCSP_OP_INTACK);
        ex(2'h3, 8'h00, 8'h01);
        issue(PCSP_OP_INTERRUPT_EXIT_INSTR);
        issue(PCSP_OP_RET);
        issue(PCSP_OP_NONE);
        idle();
        check("return", {program_counter_o, req_ready_o, int_enable_o, carry_o, zero_o}, 18'h0_200d);
        // acknowledge with interrupts enabled, so the disable is really seen
        ex(2'h0, 8'h00, 8'h42);
        ex(2'h0, 8'h01, 8'h00);
        issue(PCSP_OP_INTACK);
        idle();
        check("disable", {program_counter_o, 3'h0, int_enable_o}, 18'h0_0040);
        r.acc = rnd();
        issue(PCSP_OP_LDPSP);
        idle();
        check("load", {10'h000, program_stack_pointer_o}, {10'h000, r.acc});
        v1 = rnd();
        v2 = rnd();
        r.acc = v1;
        ex(2'h0, 8'hff, v1);
        issue(PCSP_OP_PUSH);
        r.acc = v2;
        ex(2'h0, 8'hfe, v2);
        issue(PCSP_OP_PUSH);
        ex(2'h1, 8'h00, v2);
        issue(PCSP_OP_POP);
        ex(2'h1, 8'h00, v1);
        issue(PCSP_OP_POP);
        r.acc = 8'h20;
        ex(2'h2, 8'h00, 8'h00);
        issue(PCSP_OP_SWAPDSP);
        r.amode = PCSP_AM_IMM;
        r.operand = rnd();
        ex(2'h1, 8'h00, r.operand);
        issue(PCSP_OP_OPADDR);
        r.amode = PCSP_AM_DIRECT;
        r.operand = 8'hfe;
        ex(2'h1, 8'h00, v2);
        issue(PCSP_OP_OPADDR);
        r.amode = PCSP_AM_INDEX;
        r.operand = 8'hf0;
        r.idx = 8'h0f;
        ex(2'h1, 8'h00, v1);
        issue(PCSP_OP_OPADDR);
        idle();
        check("data pointer", {10'h000, data_stack_pointer_o}, 18'h0_0020);
        reset();
        check("leftover", 18'(q.size()), 18'h0_0000);
        give_verdict();
    end
endmodule : testbench

bind pcsp_core pcsp_core_props u_props (.*);
